// ---- logic/prm_pkg.sv ----
// package: address map, reset values and field layout of the processor register block
// Function
// - every register sits in its own 4-byte aligned slot and is reached with whole-word accesses.
// - read/write registers return the last value written; processor writes never alter read-only ones.
// - the host bus reset initialises every register exactly as power-up does.
// - a command reset restarts the processor and drives every listed register to its restart value.
// - a readable reset-cause register records whether the last reset was full or command.
// - each register has separate full-reset and restart values; some bits survive a restart.
// - bits kept across a restart hold their exact previous value; undefined bits may take any value.
// - read-only registers and bits hold no firmware start-up value and only reflect hardware state.
// - five identical timer ports, picked by an address digit, each with control, preset, value, command.
// - two identical bus master channel register sets are decoded at address digits 3 and 4.
package prm_pkg;

	localparam int NUM_RW     = 16;
	localparam int NUM_RO     = 13;
	localparam int NUM_TMR    = 5;
	localparam int TMR_RW     = 3;
	localparam int NUM_CHAN   = 2;
	localparam int CHAN_RW    = 7;
	localparam int CHAN_SLOTS = 8;

	// 0 enable/detect, 1 local bus base, 2-4 host command block, 5-7 debug port,
	// 8-11 protection and single-bit, 12-15 memory, arbitration, bus config, force error
	localparam logic [31:0] RW_ADDR [NUM_RW] = '{
		32'h0a00_0004, 32'h1ffa_0024, 32'h1ffa_200c, 32'h1ffa_2010,
		32'h1ffa_2014, 32'h1ffb_8000, 32'h1ffb_8004, 32'h1ffb_8008,
		32'h1ffb_9000, 32'h1ffb_9004, 32'h1ffb_9008, 32'h1ffb_9030,
		32'h1ffb_a004, 32'h1ffb_a008, 32'h1ffb_a00c, 32'h1ffb_a010};

	// parity/exception, command, attention, subsystem control, then traps and status words
	localparam logic [31:0] RO_ADDR [NUM_RO] = '{
		32'h1ffa_0020, 32'h1ffa_2000, 32'h1ffa_2004, 32'h1ffa_2008,
		32'h1ffb_9010, 32'h1ffb_9014, 32'h1ffb_9018, 32'h1ffb_901c,
		32'h1ffb_9020, 32'h1ffb_9024, 32'h1ffb_902c, 32'h1ffb_9034,
		32'h1ffb_9038};

	localparam logic [31:0] CAUSE_ADDR = 32'h1ffa_0014;
	localparam logic [1:0]  CAUSE_FULL = 2'h1;
	localparam logic [1:0]  CAUSE_CMD  = 2'h2;
	localparam logic [1:0]  WORD_ALIGN = 2'h0;

	localparam logic [15:0] TMR_REGION       = 16'h1ffb;
	localparam logic [15:0] CHAN_REGION      = 16'h1ffa;
	localparam logic [3:0]  CHAN_FIRST_DIGIT = 4'h3;

	// control, preset, command; present value is read-only
	localparam logic [11:0] TMR_RW_OFS [TMR_RW] = '{12'h000, 12'h004, 12'h00c};
	localparam logic [11:0] TMR_VALUE_OFS       = 12'h008;

	// card address, system address, byte count, control, address, list pointer, command
	localparam logic [11:0] CHAN_RW_OFS [CHAN_RW] = '{
		12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h01c};
	localparam logic [11:0] CHAN_STAT_OFS = 12'h018;

	localparam logic [31:0] RW_FULL_RST [NUM_RW] = '{default: 32'h0000_0000};
	localparam logic [31:0] RW_CMD_RST  [NUM_RW] = '{default: 32'h0000_0000};
	// base address, debug port setup and memory setup survive a restart
	localparam logic [31:0] RW_KEEP [NUM_RW] = '{
		32'h0000_0000, 32'hffff_ffff, 32'h0000_0000, 32'h0000_0000,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'hffff_ffff,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'hffff_ffff, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

	localparam logic [31:0] TMR_FULL_RST  = 32'h0000_0000;
	localparam logic [31:0] TMR_CMD_RST   = 32'h0000_0000;
	localparam logic [31:0] TMR_KEEP      = 32'h0000_0000;
	localparam logic [31:0] CHAN_FULL_RST = 32'h0000_0000;
	localparam logic [31:0] CHAN_CMD_RST  = 32'h0000_0000;
	localparam logic [31:0] CHAN_KEEP     = 32'h0000_0000;

endpackage

// ---- logic/prm_register_map.sv ----
// register map: decode, storage, reset handling and read-back for the processor's local bus
module prm_register_map (
	// clock and resets
	input  wire logic                                         i_clk,
	input  wire logic                                         i_rst,
	input  wire logic                                         i_cmd_rst,
	// processor word access
	input  wire logic                                         i_req,
	input  wire logic                                         i_we,
	input  wire logic [31:0]                                  i_addr,
	input  wire logic [31:0]                                  i_wdata,
	output logic                                              o_ack,
	output logic      [31:0]                                  o_rdata,
	// hardware state shown in read-only registers
	input  wire logic [prm_pkg::NUM_RO-1:0][31:0]             i_ro_state,
	input  wire logic [prm_pkg::NUM_TMR-1:0][31:0]            i_tmr_value,
	input  wire logic [prm_pkg::NUM_CHAN-1:0][31:0]           i_chan_status,
	// stored control words toward the units
	output logic      [prm_pkg::NUM_RW-1:0][31:0]             o_rw_regs,
	output logic      [prm_pkg::NUM_TMR-1:0][31:0]            o_tmr_ctrl,
	output logic      [prm_pkg::NUM_TMR-1:0][31:0]            o_tmr_preset,
	output logic      [prm_pkg::NUM_TMR-1:0][31:0]            o_tmr_cmd,
	output logic      [prm_pkg::NUM_CHAN-1:0][prm_pkg::CHAN_RW-1:0][31:0] o_chan_regs,
	// last reset kind
	output logic      [1:0]                                   o_reset_cause
);
	import prm_pkg::*;

	// timer port number from the address, -1 when outside the timer ranges
	function automatic int tmr_port(input logic [31:0] a);
		tmr_port = -1;
		if (a[31:16] == TMR_REGION && a[11:4] == 8'h00 && a[1:0] == WORD_ALIGN) begin
			if (int'(a[15:12]) < NUM_TMR) begin
				tmr_port = int'(a[15:12]);
			end
		end
	endfunction

	// channel slot = channel * CHAN_SLOTS + word, word CHAN_RW meaning status; -1 if none
	function automatic int chan_slot(input logic [31:0] a);
		int c;
		c = int'(a[15:12]) - int'(CHAN_FIRST_DIGIT);
		chan_slot = -1;
		if (a[31:16] == CHAN_REGION && a[11:8] == 4'h0 && c >= 0 && c < NUM_CHAN) begin
			for (int r = 0; r < CHAN_RW; r++) begin
				if (a[11:0] == CHAN_RW_OFS[r]) begin
					chan_slot = c * CHAN_SLOTS + r;
				end
			end
			if (a[11:0] == CHAN_STAT_OFS) begin
				chan_slot = c * CHAN_SLOTS + CHAN_RW;
			end
		end
	endfunction

	// unaligned addresses match nothing, so they fall into the dropped/zero case
	logic        aligned;
	logic        wr_ok;
	logic        rd_ok;
	logic [31:0] rw_q [NUM_RW];
	logic [31:0] chan_q [NUM_CHAN][CHAN_RW];
	logic [31:0] tmr_rdata [NUM_TMR];
	logic [1:0]  cause;
	logic [31:0] next_rdata;
	logic        next_mapped;
	int          wr_chan;
	int          wr_tmr;

	assign aligned = i_addr[1:0] == WORD_ALIGN;
	assign wr_ok   = i_req && i_we && aligned;
	assign rd_ok   = i_req && !i_we && aligned;
	assign wr_chan = chan_slot(i_addr);
	assign wr_tmr  = tmr_port(i_addr);

	// general read/write registers
	genvar g;
	genvar r;
	generate
		for (g = 0; g < NUM_RW; g++) begin : g_rw
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					rw_q[g] <= RW_FULL_RST[g];
				end else if (i_cmd_rst) begin
					// restart wins over a write landing in the same cycle
					rw_q[g] <= (rw_q[g] & RW_KEEP[g]) | (RW_CMD_RST[g] & ~RW_KEEP[g]);
				end else if (wr_ok && i_addr == RW_ADDR[g]) begin
					rw_q[g] <= i_wdata;
				end
			end
			assign o_rw_regs[g] = rw_q[g];

			sequence s_rw_write;
				wr_ok && !i_cmd_rst && i_addr == RW_ADDR[g];
			endsequence

			sequence s_restart;
				i_cmd_rst;
			endsequence

			a_rw_store: assert property (@(posedge i_clk) disable iff (i_rst)
				s_rw_write |=> rw_q[g] == $past(i_wdata))
				else $error("read/write register lost its written value");

			a_rw_readback: assert property (@(posedge i_clk) disable iff (i_rst)
				s_rw_write ##1 (rd_ok && !i_cmd_rst && i_addr == RW_ADDR[g])
				|=> o_ack && o_rdata == $past(i_wdata, 2))
				else $error("read-back differs from value written");

			a_full_init: assert property (@(posedge i_clk) disable iff (i_rst)
				$fell(i_rst) |-> rw_q[g] == RW_FULL_RST[g])
				else $error("register not at power-up value after bus reset");

			a_restart_value: assert property (@(posedge i_clk) disable iff (i_rst)
				s_restart |=> (rw_q[g] & ~RW_KEEP[g]) == (RW_CMD_RST[g] & ~RW_KEEP[g]))
				else $error("register not at restart value after command reset");

			a_keep_bits: assert property (@(posedge i_clk) disable iff (i_rst)
				s_restart |=> (rw_q[g] & RW_KEEP[g]) == ($past(rw_q[g]) & RW_KEEP[g]))
				else $error("kept bit changed across command reset");
		end
	endgenerate

	// two bus master channels, same layout, picked by the address digit
	generate
		for (g = 0; g < NUM_CHAN; g++) begin : g_chan
			for (r = 0; r < CHAN_RW; r++) begin : g_word
				always_ff @(posedge i_clk) begin
					if (i_rst) begin
						chan_q[g][r] <= CHAN_FULL_RST;
					end else if (i_cmd_rst) begin
						chan_q[g][r] <= (chan_q[g][r] & CHAN_KEEP)
							| (CHAN_CMD_RST & ~CHAN_KEEP);
					end else if (wr_ok && wr_chan == g * CHAN_SLOTS + r) begin
						chan_q[g][r] <= i_wdata;
					end
				end
				assign o_chan_regs[g][r] = chan_q[g][r];

				a_chan_store: assert property (@(posedge i_clk) disable iff (i_rst)
					(wr_ok && !i_cmd_rst && i_addr[15:12] == CHAN_FIRST_DIGIT + 4'(g)
						&& i_addr[31:16] == CHAN_REGION && i_addr[11:0] == CHAN_RW_OFS[r])
					|=> chan_q[g][r] == $past(i_wdata))
					else $error("channel word not written at its digit");

				a_chan_isolate: assert property (@(posedge i_clk) disable iff (i_rst)
					(wr_ok && !i_cmd_rst && i_addr[15:12] != CHAN_FIRST_DIGIT + 4'(g))
					|=> $stable(chan_q[g][r]))
					else $error("write to another digit changed this channel");
			end
		end
	endgenerate

	// five timer ports, identical
	generate
		for (g = 0; g < NUM_TMR; g++) begin : g_tmr
			prm_timer_port u_port (
				.i_clk     (i_clk),
				.i_rst     (i_rst),
				.i_cmd_rst (i_cmd_rst),
				.i_sel     (i_req && wr_tmr == g),
				.i_we      (i_we),
				.i_ofs     (i_addr[11:0]),
				.i_wdata   (i_wdata),
				.i_value   (i_tmr_value[g]),
				.o_ctrl    (o_tmr_ctrl[g]),
				.o_preset  (o_tmr_preset[g]),
				.o_cmd     (o_tmr_cmd[g]),
				.o_rdata   (tmr_rdata[g])
			);
		end
	endgenerate

	// reset cause: a full reset also covers any restart pending with it
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cause <= CAUSE_FULL;
		end else if (i_cmd_rst) begin
			cause <= CAUSE_CMD;
		end
	end
	assign o_reset_cause = cause;

	a_cause_track: assert property (@(posedge i_clk) disable iff (i_rst)
		($fell(i_rst) |-> cause == CAUSE_FULL)
		and (i_cmd_rst |=> cause == CAUSE_CMD))
		else $error("reset cause does not match last reset");

	// read mux; read-only words come straight from hardware state, never from storage
	always_comb begin
		int t;
		int s;
		t = tmr_port(i_addr);
		s = chan_slot(i_addr);
		next_rdata  = 32'h0000_0000;
		next_mapped = 1'b0;
		if (aligned) begin
			for (int k = 0; k < NUM_RW; k++) begin
				if (i_addr == RW_ADDR[k]) begin
					next_rdata  = rw_q[k];
					next_mapped = 1'b1;
				end
			end
			for (int k = 0; k < NUM_RO; k++) begin
				if (i_addr == RO_ADDR[k]) begin
					next_rdata  = i_ro_state[k];
					next_mapped = 1'b1;
				end
			end
			if (i_addr == CAUSE_ADDR) begin
				next_rdata  = {30'h0, cause};
				next_mapped = 1'b1;
			end
			if (t >= 0 && (i_addr[3:0] != 4'h0 || i_addr[11:0] == 12'h000)) begin
				next_rdata  = tmr_rdata[t];
				next_mapped = 1'b1;
			end
			if (s >= 0) begin
				if (s % CHAN_SLOTS == CHAN_RW) begin
					next_rdata = i_chan_status[s / CHAN_SLOTS];
				end else begin
					next_rdata = chan_q[s / CHAN_SLOTS][s % CHAN_SLOTS];
				end
				next_mapped = 1'b1;
			end
		end
	end

	// every access is answered one cycle later; unmatched reads give zero
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_ack <= 1'b0;
		end else begin
			o_ack <= i_req;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 32'h0000_0000;
		end else if (rd_ok) begin
			o_rdata <= next_rdata;
		end else begin
			o_rdata <= 32'h0000_0000;
		end
	end

	a_ack_timing: assert property (@(posedge i_clk) disable iff (i_rst)
		i_req |=> o_ack ##1 (o_ack == $past(i_req)))
		else $error("access not answered in the next cycle");

	a_unmapped_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_req && !next_mapped) |=> o_ack && o_rdata == 32'h0000_0000)
		else $error("unmapped access did not read as zero");

	a_unaligned_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_req && !i_we && !aligned) |=> o_rdata == 32'h0000_0000)
		else $error("partial-word address returned data");

	a_ro_write_none: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_ok && !i_cmd_rst && i_addr == RO_ADDR[0]) |=> $stable(o_rw_regs))
		else $error("write to a read-only word changed storage");

	a_ro_report: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_ok && i_addr == RO_ADDR[1]) |=> o_rdata == $past(i_ro_state[1]))
		else $error("read-only word does not show hardware state");

	a_timer_value: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_ok && wr_tmr == NUM_TMR - 1 && i_addr[11:0] == TMR_VALUE_OFS)
		|=> o_rdata == $past(i_tmr_value[NUM_TMR-1]))
		else $error("last timer port present value not returned");

	a_chan_status: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_ok && wr_chan == CHAN_SLOTS + CHAN_RW) |=> o_rdata == $past(i_chan_status[1]))
		else $error("second channel status not returned");

	// bus answer: the data lines stay at zero outside a load answer
	a_ack_idle: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_req |=> !o_ack)
		else $error("answer without an access");

	a_idle_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		!rd_ok |=> o_rdata == 32'h0000_0000)
		else $error("read data not zero outside a load");

	a_store_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_req && i_we) |=> o_ack && o_rdata == 32'h0000_0000)
		else $error("store not answered with zero data");

	a_cause_read: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_ok && i_addr == CAUSE_ADDR) |=> o_rdata == {30'h0, $past(cause)})
		else $error("reset cause read-back wrong");

	a_cause_fixed: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_ok && !i_cmd_rst && i_addr == CAUSE_ADDR) |=> $stable(cause))
		else $error("store changed the reset cause");

	a_restart_wins: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_ok && i_cmd_rst && i_addr == RW_ADDR[1])
		|=> (o_rw_regs[1] & RW_KEEP[1]) == ($past(o_rw_regs[1]) & RW_KEEP[1]))
		else $error("store in the restart cycle was not dropped");

	a_tmr_ctrl_read: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_ok && wr_tmr == 0 && i_addr[11:0] == TMR_RW_OFS[0])
		|=> o_rdata == $past(o_tmr_ctrl[0]))
		else $error("first timer control word not returned");

	a_tmr_value_ro: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_ok && !i_cmd_rst && wr_tmr >= 0 && i_addr[11:0] == TMR_VALUE_OFS)
		|=> $stable(o_tmr_ctrl) && $stable(o_tmr_preset) && $stable(o_tmr_cmd))
		else $error("store to a present value changed a timer word");

	a_tmr_restart: assert property (@(posedge i_clk) disable iff (i_rst)
		i_cmd_rst |=> (o_tmr_cmd[NUM_TMR-1] & ~TMR_KEEP) == (TMR_CMD_RST & ~TMR_KEEP))
		else $error("timer word not at restart value");

	a_chan_first_read: assert property (@(posedge i_clk) disable iff (i_rst)
		(rd_ok && wr_chan == 0) |=> o_rdata == $past(o_chan_regs[0][0]))
		else $error("first channel word not returned");

	a_chan_stat_ro: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_ok && !i_cmd_rst && wr_chan >= 0 && wr_chan % CHAN_SLOTS == CHAN_RW)
		|=> $stable(o_chan_regs))
		else $error("store to a channel status changed channel words");

	a_chan_restart: assert property (@(posedge i_clk) disable iff (i_rst)
		i_cmd_rst
		|=> (o_chan_regs[NUM_CHAN-1][CHAN_RW-1] & ~CHAN_KEEP) == (CHAN_CMD_RST & ~CHAN_KEEP))
		else $error("channel word not at restart value");

	a_unmapped_keep: assert property (@(posedge i_clk) disable iff (i_rst)
		(wr_ok && !i_cmd_rst && !next_mapped)
		|=> $stable(o_rw_regs) && $stable(o_chan_regs) && $stable(o_tmr_ctrl))
		else $error("store to an unmapped word changed storage");

	a_unaligned_keep: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_req && i_we && !aligned && !i_cmd_rst) |=> $stable(o_rw_regs) && $stable(o_chan_regs))
		else $error("partial-word store changed storage");

	a_full_chan: assert property (@(posedge i_clk) disable iff (i_rst)
		$fell(i_rst) |-> o_chan_regs[NUM_CHAN-1][CHAN_RW-1] == CHAN_FULL_RST)
		else $error("channel word not at power-up value after bus reset");

	// every read-only word shows its input and ignores stores
	generate
		for (g = 0; g < NUM_RO; g++) begin : g_ro
			a_ro_each: assert property (@(posedge i_clk) disable iff (i_rst)
				(rd_ok && i_addr == RO_ADDR[g]) |=> o_rdata == $past(i_ro_state[g]))
				else $error("read-only word does not follow its input");

			a_ro_keep: assert property (@(posedge i_clk) disable iff (i_rst)
				(wr_ok && !i_cmd_rst && i_addr == RO_ADDR[g]) |=> $stable(o_rw_regs))
				else $error("store to a read-only word changed storage");
		end
	endgenerate

endmodule // prm_register_map

// ---- logic/prm_timer_port.sv ----
// one timer port: control, preset and command words plus the live present value
module prm_timer_port (
	// clock and resets
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_cmd_rst,
	// access from the decoder
	input  wire logic        i_sel,
	input  wire logic        i_we,
	input  wire logic [11:0] i_ofs,
	input  wire logic [31:0] i_wdata,
	input  wire logic [31:0] i_value,
	// stored words and read data
	output logic      [31:0] o_ctrl,
	output logic      [31:0] o_preset,
	output logic      [31:0] o_cmd,
	output logic      [31:0] o_rdata
);
	import prm_pkg::*;

	logic [31:0] word_q [TMR_RW];

	genvar g;
	generate
		for (g = 0; g < TMR_RW; g++) begin : g_word
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					word_q[g] <= TMR_FULL_RST;
				end else if (i_cmd_rst) begin
					word_q[g] <= (word_q[g] & TMR_KEEP) | (TMR_CMD_RST & ~TMR_KEEP);
				end else if (i_sel && i_we && i_ofs == TMR_RW_OFS[g]) begin
					word_q[g] <= i_wdata;
				end
			end

			a_timer_store: assert property (@(posedge i_clk) disable iff (i_rst)
				(i_sel && i_we && !i_cmd_rst && i_ofs == TMR_RW_OFS[g])
				|=> word_q[g] == $past(i_wdata))
				else $error("timer word did not take the written value");
		end
	endgenerate

	always_comb begin
		o_rdata = 32'h0000_0000;
		for (int k = 0; k < TMR_RW; k++) begin
			if (i_ofs == TMR_RW_OFS[k]) begin
				o_rdata = word_q[k];
			end
		end
		if (i_ofs == TMR_VALUE_OFS) begin
			o_rdata = i_value;
		end
	end

	assign o_ctrl   = word_q[0];
	assign o_preset = word_q[1];
	assign o_cmd    = word_q[2];

endmodule // prm_timer_port

// ---- tb/prm_cpu_model.sv ----
// partner model: processor core issuing whole-word loads and stores on the local bus
module prm_cpu_model (
	// clock
	input  wire logic        i_clk,
	// word access toward the register map
	output logic             o_req,
	output logic             o_we,
	output logic      [31:0] o_addr,
	output logic      [31:0] o_wdata,
	input  wire logic        i_ack,
	input  wire logic [31:0] i_rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		o_req = 1'b0;
		o_we = 1'b0;
		o_addr = 32'h0;
		o_wdata = 32'h0;
	end

	// the answer always comes one edge later, so the request stands for exactly one edge;
	// holding it longer would be taken as a second access
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic k);
		@(negedge i_clk);
		o_req = 1'b1;
		o_we = w;
		o_addr = a;
		o_wdata = d;
		@(negedge i_clk);
		q = i_rdata;
		k = i_ack;
		o_req = 1'b0;
		o_we = 1'b0;
		// released lines show the inverse so stale values cannot pass for good ones
		o_addr = ~a;
		o_wdata = ~d;
	endtask

	// store then load at one address with no idle cycle between them
	task automatic wr_rd(input logic [31:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic k);
		@(negedge i_clk);
		o_req = 1'b1;
		o_we = 1'b1;
		o_addr = a;
		o_wdata = d;
		@(negedge i_clk);
		k = i_ack;
		o_we = 1'b0;
		o_wdata = ~d;
		@(negedge i_clk);
		q = i_rdata;
		k = k && i_ack;
		o_req = 1'b0;
		o_addr = ~a;
	endtask
endmodule // prm_cpu_model

// ---- tb/prm_register_map_bench.sv ----
// testbench: word accesses, both reset kinds and read-back of the processor register map
module prm_register_map_bench import prm_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic                                   i_clk = 1'b0;
	logic                                   i_rst = 1'b1;
	logic                                   i_cmd_rst = 1'b0;
	logic                                   req, we, ack;
	logic [31:0]                            addr, wdata, rdata;
	logic [NUM_RO-1:0][31:0]                ro_state;
	logic [NUM_TMR-1:0][31:0]               tmr_value, tmr_ctrl, tmr_preset, tmr_cmd;
	logic [NUM_CHAN-1:0][31:0]              chan_status;
	logic [NUM_RW-1:0][31:0]                rw_regs;
	logic [NUM_CHAN-1:0][CHAN_RW-1:0][31:0] chan_regs;
	logic [1:0]                             reset_cause;
	int                                     error_cnt = 0;
	int                                     compares = 0;
	int                                     cyc = 0;
	logic [31:0]                            b2b_q;
	logic                                   b2b_k;

	always #12.5 i_clk = ~i_clk;

	prm_cpu_model cpu_u (.i_clk(i_clk), .o_req(req), .o_we(we), .o_addr(addr),
		.o_wdata(wdata), .i_ack(ack), .i_rdata(rdata));

	prm_register_map dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_cmd_rst(i_cmd_rst),
		.i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wdata), .o_ack(ack),
		.o_rdata(rdata), .i_ro_state(ro_state), .i_tmr_value(tmr_value),
		.i_chan_status(chan_status), .o_rw_regs(rw_regs), .o_tmr_ctrl(tmr_ctrl),
		.o_tmr_preset(tmr_preset), .o_tmr_cmd(tmr_cmd), .o_chan_regs(chan_regs),
		.o_reset_cause(reset_cause));

	task automatic test_done();
		if (error_cnt == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// a few hundred accesses of two cycles each fit well inside this ceiling
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        k;
		cpu_u.xfer(1'b1, a, d, q, k);
		chk({31'h0, k}, 32'h1);
		chk(q, 32'h0);
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic        k;
		cpu_u.xfer(1'b0, a, 32'h0, q, k);
		chk({31'h0, k}, 32'h1);
		chk(q, e);
	endtask

	function automatic logic [31:0] pat(input int i);
		return {8'h5a, 8'(i), 16'hc3e1};
	endfunction

	function automatic logic [31:0] taddr(input int x, input int j);
		return {16'h1ffb, 4'(x), 12'(j * 4)};
	endfunction

	function automatic logic [31:0] caddr(input int c, input int j);
		return {16'h1ffa, 4'(3 + c), 12'(j * 4)};
	endfunction

	initial begin
		for (int i = 0; i < NUM_RO; i++) ro_state[i] = ~pat(i);
		for (int x = 0; x < NUM_TMR; x++) tmr_value[x] = pat(40 + x);
		for (int c = 0; c < NUM_CHAN; c++) chan_status[c] = pat(50 + c);
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		rd(CAUSE_ADDR, {30'h0, CAUSE_FULL});
		chk({30'h0, reset_cause}, {30'h0, CAUSE_FULL});
		for (int i = 0; i < NUM_RW; i++) rd(RW_ADDR[i], RW_FULL_RST[i]);
		for (int i = 0; i < NUM_RW; i++) wr(RW_ADDR[i], pat(i));
		for (int i = 0; i < NUM_RW; i++) begin
			rd(RW_ADDR[i], pat(i));
			chk(rw_regs[i], pat(i));
		end
		// a load right after a store sees the new value
		cpu_u.wr_rd(RW_ADDR[2], pat(77), b2b_q, b2b_k);
		chk({31'h0, b2b_k}, 32'h1);
		chk(b2b_q, pat(77));
		chk(rw_regs[2], pat(77));
		// read-only words ignore stores and show only the hardware inputs
		for (int i = 0; i < NUM_RO; i++) begin
			wr(RO_ADDR[i], pat(i));
			rd(RO_ADDR[i], ~pat(i));
		end
		wr(CAUSE_ADDR, 32'hffff_ffff);
		rd(CAUSE_ADDR, {30'h0, CAUSE_FULL});
		for (int x = 0; x < NUM_TMR; x++) begin
			for (int j = 0; j < 4; j++) wr(taddr(x, j), pat(10 * x + j));
			for (int j = 0; j < 4; j++) rd(taddr(x, j), pat(j == 2 ? 40 + x : 10 * x + j));
			chk(tmr_ctrl[x], pat(10 * x));
			chk(tmr_preset[x], pat(10 * x + 1));
			chk(tmr_cmd[x], pat(10 * x + 3));
		end
		rd(taddr(5, 0), 32'h0);
		for (int c = 0; c < NUM_CHAN; c++) begin
			for (int j = 0; j < 8; j++) wr(caddr(c, j), pat(100 + 10 * c + j));
			for (int j = 0; j < 8; j++) begin
				rd(caddr(c, j), pat(j == 6 ? 50 + c : 100 + 10 * c + j));
				if (j != 6) chk(chan_regs[c][j < 6 ? j : j - 1], pat(100 + 10 * c + j));
			end
		end
		rd(caddr(2, 0), 32'h0);
		wr(32'h1ffa_0028, 32'hffff_ffff);
		rd(32'h1ffa_0028, 32'h0);
		wr(32'h1ffa_0026, 32'h0);
		rd(32'h1ffa_0025, 32'h0);
		rd(RW_ADDR[1], pat(1));
		// restart: kept bits hold their old value, the rest take restart values
		// a store landing in the restart cycle is dropped
		fork
			wr(RW_ADDR[1], pat(99));
			begin
				@(negedge i_clk);
				i_cmd_rst = 1'b1;
				@(negedge i_clk);
				i_cmd_rst = 1'b0;
			end
		join
		rd(CAUSE_ADDR, {30'h0, CAUSE_CMD});
		chk({30'h0, reset_cause}, {30'h0, CAUSE_CMD});
		for (int i = 0; i < NUM_RW; i++) begin
			rd(RW_ADDR[i], (pat(i) & RW_KEEP[i]) | (RW_CMD_RST[i] & ~RW_KEEP[i]));
		end
		rd(taddr(4, 3), (pat(43) & TMR_KEEP) | (TMR_CMD_RST & ~TMR_KEEP));
		rd(caddr(1, 7), (pat(117) & CHAN_KEEP) | (CHAN_CMD_RST & ~CHAN_KEEP));
		rd(RO_ADDR[0], ~pat(0));
		// full reset clears even the bits that survived the restart
		@(negedge i_clk);
		i_rst = 1'b1;
		@(negedge i_clk);
		i_rst = 1'b0;
		rd(CAUSE_ADDR, {30'h0, CAUSE_FULL});
		for (int i = 0; i < NUM_RW; i++) rd(RW_ADDR[i], RW_FULL_RST[i]);
		rd(taddr(0, 0), TMR_FULL_RST);
		rd(caddr(0, 0), CHAN_FULL_RST);
		test_done();
	end
endmodule // prm_register_map_bench
